//--- pkg/serial_status_defs.vh
`ifndef SERIAL_STATUS_DEFS_VH
`define SERIAL_STATUS_DEFS_VH

// ----------------------------------------
// register addresses on the plain port
// ----------------------------------------
`define ADDR_W 3
`define ADDR_FORMAT 3'h0
`define ADDR_CONTROL 3'h1
`define ADDR_FLAGS 3'h2
`define ADDR_TX_HOLD 3'h3
`define ADDR_RX_HOLD 3'h4

// ----------------------------------------
// reset values
// ----------------------------------------
`define FORMAT_RST 8'h00
`define CONTROL_RST 8'h00
`define FLAGS_RST 8'h84
`define HOLD_RST 8'h00

// ----------------------------------------
// serial_format_reg fields
// ----------------------------------------
`define FMT_SYNC 7

// ----------------------------------------
// serial_control_reg fields
// ----------------------------------------
`define CTL_TX_ON 5
`define CTL_RX_ON 4
`define CTL_TX_FINISHED_IE 2
`define CTL_CLK_SRC 1
`define CTL_CLK_OUT 0

// ----------------------------------------
// serial_flags_reg fields
// ----------------------------------------
`define FLG_TX_HOLDING_EMPTY 7
`define FLG_RX_HOLDING_FULL 6
`define FLG_OVR 5
`define FLG_FRM 4
`define FLG_PAR 3
`define FLG_TX_FINISHED 2
`define FLG_RMPB 1
`define FLG_TMPB 0

// ----------------------------------------
// timing: ticks of the x16 enable per half clock
// ----------------------------------------
`define SCK_HALF_TICKS 8

`endif

//--- rtl/serial_clk_sync.v
`timescale 1ns/1ns
`include "serial_status_defs.vh"

// ----------------------------------------
// two-flop synchroniser and rise detect for the serial clock pin
// ----------------------------------------
module serial_clk_sync (
  input wire core_clk,
  input wire rst_b,
  input wire pin_in,
  output reg pin_level,
  output wire pin_rise
);

  reg meta;
  reg last;

  // meta feeds only pin_level; edges are seen on the second stage
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      pin_level <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_in;
      pin_level <= meta;
      last <= pin_level;
    end
  end

  // one-cycle pulse on each rising edge of the pin
  assign pin_rise = pin_level & ~last;

endmodule

//--- rtl/serial_status_ctrl.v
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "serial_status_defs.vh"

module serial_status_ctrl #(
  parameter SCK_HALF = `SCK_HALF_TICKS
) (
  input wire core_clk,
  input wire rst_b,
  input wire standby,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rd_data,
  input wire tick16,
  input wire tx_load,
  input wire tx_last_bit,
  input wire rx_done,
  input wire [7:0] rx_data,
  input wire rx_mpb,
  input wire rx_frame_err,
  input wire rx_parity_err,
  input wire sck_in,
  output reg sck_out,
  output wire sck_oe,
  output wire clk_en,
  output wire ext_clk_sel,
  output wire sync_mode,
  output wire tx_on,
  output wire rx_on,
  output reg [7:0] tx_data,
  output wire tx_data_valid,
  output wire tx_mpb,
  output wire rx_halt,
  output wire tx_halt,
  output wire tx_end_irq
);

  // ----------------------------------------
  // functions
  // ----------------------------------------

  // address match for one register
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] format_reg;
  reg [7:0] control_reg;
  reg [7:0] rx_holding;
  reg tx_holding_empty;
  reg rx_holding_full;
  reg ovr;
  reg frm;
  reg par;
  reg tx_finished;
  reg rmpb;
  reg tmpb;
  reg [4:0] arm;
  reg [7:0] sck_cnt;

  reg next_tx_holding_empty;
  reg next_rx_holding_full;
  reg next_ovr;
  reg next_frm;
  reg next_par;
  reg next_tx_finished;
  reg next_rmpb;
  reg next_store;
  reg [4:0] next_arm;
  reg [4:0] clr_mask;

  wire pin_level;
  wire pin_rise;

  // ----------------------------------------
  // strobes and decoded control bits
  // ----------------------------------------

  // single-cycle access strobes per register
  wire wr_fmt = wr_en & hit(addr, `ADDR_FORMAT);
  wire wr_ctl = wr_en & hit(addr, `ADDR_CONTROL);
  wire wr_flg = wr_en & hit(addr, `ADDR_FLAGS);
  wire wr_tdr = wr_en & hit(addr, `ADDR_TX_HOLD);
  wire rd_flg = rd_en & hit(addr, `ADDR_FLAGS);
  wire rd_rdr = rd_en & hit(addr, `ADDR_RX_HOLD);

  assign sync_mode = format_reg[`FMT_SYNC];
  assign tx_on = control_reg[`CTL_TX_ON];
  assign rx_on = control_reg[`CTL_RX_ON];
  assign ext_clk_sel = control_reg[`CTL_CLK_SRC];

  // transmitter being switched off by this write
  wire tx_off_now = wr_ctl & tx_on & ~wr_data[`CTL_TX_ON];

  // current flags as one byte
  wire [7:0] flags = {tx_holding_empty, rx_holding_full, ovr, frm, par, tx_finished, rmpb, tmpb};
  wire [4:0] clear_flags = {tx_holding_empty, rx_holding_full, ovr, frm, par};

  // ----------------------------------------
  // halting and interrupt
  // ----------------------------------------

  // any error flag stops reception; sync mode also stops sending
  assign rx_halt = ovr | frm | par;
  assign tx_halt = sync_mode & rx_halt;

  // request follows tx_finished while enabled
  assign tx_end_irq = control_reg[`CTL_TX_FINISHED_IE] & tx_finished;

  assign tx_data_valid = ~tx_holding_empty;
  assign tx_mpb = tmpb;

  // ----------------------------------------
  // clock source and pin direction
  // ----------------------------------------

  // drive pin only when internally clocked and sync or output asked
  assign sck_oe = ~ext_clk_sel & (sync_mode | control_reg[`CTL_CLK_OUT]);

  // external: each pin rise is one clock; in async it runs at 16x rate
  assign clk_en = ext_clk_sel ? pin_rise : tick16;

  // pin sampled into the core domain
  serial_clk_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(sck_in),
    .pin_level(pin_level),
    .pin_rise(pin_rise)
  );

  // output clock at the bit rate: toggle every SCK_HALF x16 ticks
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_cnt <= 8'h00;
      sck_out <= 1'b1;
    end else if (!sck_oe) begin
      sck_cnt <= 8'h00;
      sck_out <= 1'b1;
    end else if (tick16) begin
      if (sck_cnt == SCK_HALF[7:0] - 8'h01) begin
        sck_cnt <= 8'h00;
        sck_out <= ~sck_out;
      end else begin
        sck_cnt <= sck_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // flag next values
  // ----------------------------------------

  // clears are applied first so that a set in the same cycle wins
  always @* begin
    next_tx_holding_empty = tx_holding_empty;
    next_rx_holding_full = rx_holding_full;
    next_ovr = ovr;
    next_frm = frm;
    next_par = par;
    next_tx_finished = tx_finished;
    next_rmpb = rmpb;
    next_store = 1'b0;
    clr_mask = 5'h00;
    // zero written to an armed flag clears it; ones are ignored
    if (wr_flg) begin
      clr_mask = arm & ~wr_data[`FLG_TX_HOLDING_EMPTY:`FLG_PAR];
    end
    if (clr_mask[4]) begin
      next_tx_holding_empty = 1'b0;
      next_tx_finished = 1'b0;
    end
    if (clr_mask[3]) begin
      next_rx_holding_full = 1'b0;
    end
    if (clr_mask[2]) begin
      next_ovr = 1'b0;
    end
    if (clr_mask[1]) begin
      next_frm = 1'b0;
    end
    if (clr_mask[0]) begin
      next_par = 1'b0;
    end
    // loading the holding register clears holding empty and tx_finished
    if (wr_tdr) begin
      next_tx_holding_empty = 1'b0;
      next_tx_finished = 1'b0;
    end
    // reading received data empties the holding register
    if (rd_rdr) begin
      next_rx_holding_full = 1'b0;
    end
    // frame end: overrun if still full, else store or flag error
    if (rx_done & rx_on & ~rx_halt) begin
      if (rx_holding_full) begin
        next_ovr = 1'b1;
        next_rx_holding_full = 1'b1;
      end else if (rx_frame_err | rx_parity_err) begin
        next_frm = rx_frame_err;
        next_par = rx_parity_err;
      end else begin
        next_store = 1'b1;
        next_rx_holding_full = 1'b1;
        next_rmpb = rx_mpb;
      end
    end
    // holding moved to shift register
    if (tx_load) begin
      next_tx_holding_empty = 1'b1;
    end
    // last bit gone with nothing waiting
    if (tx_last_bit & tx_holding_empty) begin
      next_tx_finished = 1'b1;
    end
    // switching the transmitter off ends transmission
    if (tx_off_now) begin
      next_tx_finished = 1'b1;
    end
    // transmitter off locks holding empty
    if (!tx_on | tx_off_now) begin
      next_tx_holding_empty = 1'b1;
    end
    // arm flags read as one; drop arms consumed or whose flag fell
    next_arm = arm & ~clr_mask;
    if (rd_flg) begin
      next_arm = next_arm | clear_flags;
    end
    next_arm = next_arm & {next_tx_holding_empty, next_rx_holding_full, next_ovr, next_frm, next_par};
  end

  // ----------------------------------------
  // flag registers
  // ----------------------------------------

  // chip reset and standby both restore the reset byte
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_holding_empty <= 1'b1;
      rx_holding_full <= 1'b0;
      ovr <= 1'b0;
      frm <= 1'b0;
      par <= 1'b0;
      tx_finished <= 1'b1;
      rmpb <= 1'b0;
      tmpb <= 1'b0;
      arm <= 5'h00;
    end else if (standby) begin
      {tx_holding_empty, rx_holding_full, ovr, frm, par, tx_finished, rmpb, tmpb} <= `FLAGS_RST;
      arm <= 5'h00;
    end else begin
      tx_holding_empty <= next_tx_holding_empty;
      rx_holding_full <= next_rx_holding_full;
      ovr <= next_ovr;
      frm <= next_frm;
      par <= next_par;
      tx_finished <= next_tx_finished;
      rmpb <= next_rmpb;
      arm <= next_arm;
      if (wr_flg) begin
        tmpb <= wr_data[`FLG_TMPB];
      end
    end
  end

  // ----------------------------------------
  // control, format and data registers
  // ----------------------------------------

  // software-written registers
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      format_reg <= `FORMAT_RST;
      control_reg <= `CONTROL_RST;
      tx_data <= `HOLD_RST;
    end else begin
      if (wr_fmt) begin
        format_reg <= wr_data;
      end
      if (wr_ctl) begin
        control_reg <= wr_data;
      end
      if (wr_tdr) begin
        tx_data <= wr_data;
      end
    end
  end

  // receive holding: only a clean frame into an empty register lands
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_holding <= `HOLD_RST;
    end else if (next_store & ~standby) begin
      rx_holding <= rx_data;
    end
  end

  // ----------------------------------------
  // read port: data in the cycle after the strobe
  // ----------------------------------------

  // unmapped addresses read zero; rd_data holds until the next read
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `ADDR_FORMAT: rd_data <= format_reg;
        `ADDR_CONTROL: rd_data <= control_reg;
        `ADDR_FLAGS: rd_data <= flags;
        `ADDR_TX_HOLD: rd_data <= tx_data;
        `ADDR_RX_HOLD: rd_data <= rx_holding;
        default: rd_data <= 8'h00;
      endcase
    end
  end

endmodule

//--- tb/serial_far_end.sv
`timescale 1ns/1ns
// --------
// remote serial party
// --------
module serial_far_end (
  input wire core_clk,
  output logic sck_in,
  output logic rx_done,
  output logic [7:0] rx_data,
  output logic rx_mpb,
  output logic rx_frame_err,
  output logic rx_parity_err
);
  // idle levels
  initial begin
    sck_in = 1'b0;
    rx_done = 1'b0;
    rx_data = 8'h00;
    rx_mpb = 1'b0;
    rx_frame_err = 1'b0;
    rx_parity_err = 1'b0;
  end
  // clock burst, still outside frames
  task automatic clk_burst(input int n);
    #33;
    repeat (n) begin
      #400 sck_in = 1'b1;
      #400 sck_in = 1'b0;
    end
  endtask
  // one frame end, then qualifiers scrambled
  task automatic frame(input logic [7:0] d, input logic m, input logic fe, input logic pe);
    clk_burst(2);
    @(posedge core_clk);
    rx_done <= 1'b1;
    rx_data <= d;
    rx_mpb <= m;
    rx_frame_err <= fe;
    rx_parity_err <= pe;
    @(posedge core_clk);
    rx_done <= 1'b0;
    rx_data <= ~d;
    rx_mpb <= ~m;
    rx_frame_err <= ~fe;
    rx_parity_err <= ~pe;
  endtask
endmodule

//--- tb/serial_status_ctrl_chk.sv
`timescale 1ns/1ns
`include "serial_status_defs.vh"
// --------
// port checks
// --------
module serial_status_ctrl_chk (
  input wire core_clk,
  input wire rst_b,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rd_data,
  input wire tick16,
  input wire tx_load,
  input wire sck_in,
  input wire sck_oe,
  input wire clk_en,
  input wire ext_clk_sel,
  input wire sync_mode,
  input wire tx_on,
  input wire [7:0] tx_data,
  input wire tx_data_valid,
  input wire rx_halt,
  input wire tx_halt,
  input wire tx_end_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // holding write with no move
  sequence hold_wr_s;
    tx_on && wr_en && addr == `ADDR_TX_HOLD && !tx_load;
  endsequence
  irq_after_reset_a: assert property ($rose(rst_b) |-> !tx_end_irq)
    else $error("end request after reset");
  irq_needs_empty_a: assert property (tx_end_irq |-> !tx_data_valid)
    else $error("end request with data waiting");
  empty_while_off_a: assert property (!tx_on && !$past(tx_on) |-> !tx_data_valid)
    else $error("holding not empty while off");
  hold_load_a: assert property (hold_wr_s |=> tx_data_valid && tx_data == $past(wr_data))
    else $error("holding write not taken");
  tx_halt_a: assert property (tx_halt == (sync_mode && rx_halt))
    else $error("transmit halt wrong");
  ext_pin_in_a: assert property (ext_clk_sel |-> !sck_oe)
    else $error("pin driven with outside clock");
  sync_pin_out_a: assert property (sync_mode && !ext_clk_sel |-> sck_oe)
    else $error("sync clock not driven");
  int_clk_a: assert property (!ext_clk_sel |-> clk_en == tick16)
    else $error("internal enable wrong");
  ext_clk_a: assert property (ext_clk_sel && $rose(sck_in) |-> ##[1:3] (clk_en || !ext_clk_sel))
    else $error("pin edge not seen");
  unmapped_rd_a: assert property (rd_en && addr > 3'h4 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind serial_status_ctrl serial_status_ctrl_chk chk_i (.*);

//--- tb/serial_status_ctrl_tb.sv
`timescale 1ns/1ns
`include "serial_status_defs.vh"
// --------
// bench
// --------
module serial_status_ctrl_tb;
  logic core_clk, rst_b, standby, wr_en, rd_en, tick16, tx_load, tx_last_bit;
  logic [`ADDR_W-1:0] addr;
  logic [7:0] wr_data, rd_data, rx_data, tx_data, rv;
  logic rx_done, rx_mpb, rx_frame_err, rx_parity_err, sck_in, sck_out, sck_oe, clk_en;
  logic ext_clk_sel, sync_mode, tx_on, rx_on, tx_data_valid, tx_mpb, rx_halt, tx_halt;
  logic tx_end_irq;
  int err_total, tests_run, cyc = 0, n;
  serial_status_ctrl serial_status_ctrl_i (.*);
  serial_far_end serial_far_end_i (.*);
  // clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // tick every fourth cycle; cycle count feeds the hang limit
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    tick16 <= (cyc[1:0] == 2'b00);
  end
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask
  task automatic fl(input logic [7:0] e);
    rd(`ADDR_FLAGS);
    cmp("flags", e, rv);
  endtask
  task automatic t_reset;
    fl(8'h84);
    rd(`ADDR_CONTROL);
    cmp("control", 8'h00, rv);
    rd(3'h7);
    cmp("unmapped", 8'h00, rv);
    wr(`ADDR_FLAGS, 8'hff);
    fl(8'h85);
    cmp("tx_mpb", 8'h01, tx_mpb);
    cmp("sck_out", 8'h01, sck_out);
    // armed empty-flag clear also drops tx_finished; empty stays locked
    wr(`ADDR_FLAGS, 8'h00);
    fl(8'h80);
  endtask
  task automatic t_tx;
    wr(`ADDR_CONTROL, 8'h24);
    wr(`ADDR_TX_HOLD, 8'h5a);
    #1 cmp("tx_data", 8'h5a, tx_data);
    fl(8'h00);
    @(posedge core_clk) tx_load <= 1'b1;
    @(posedge core_clk) tx_load <= 1'b0;
    fl(8'h80);
    @(posedge core_clk) tx_last_bit <= 1'b1;
    @(posedge core_clk) tx_last_bit <= 1'b0;
    #1 cmp("irq", 8'h01, tx_end_irq);
    fl(8'h84);
    wr(`ADDR_FLAGS, 8'h00);
    #1 cmp("irq", 8'h00, tx_end_irq);
    fl(8'h00);
    @(posedge core_clk) standby <= 1'b1;
    @(posedge core_clk) standby <= 1'b0;
    fl(8'h84);
    wr(`ADDR_CONTROL, 8'h20);
    #1 cmp("irq", 8'h00, tx_end_irq);
    wr(`ADDR_TX_HOLD, 8'h33);
    wr(`ADDR_CONTROL, 8'h00);
    fl(8'h84);
  endtask
  task automatic t_rx;
    wr(`ADDR_CONTROL, 8'h10);
    #1 cmp("rx_on", 8'h01, rx_on);
    cmp("tx_on", 8'h00, tx_on);
    serial_far_end_i.frame(8'h3c, 1'b1, 1'b0, 1'b0);
    fl(8'hc6);
    rd(`ADDR_RX_HOLD);
    cmp("rx_hold", 8'h3c, rv);
    fl(8'h86);
    serial_far_end_i.frame(8'h11, 1'b1, 1'b1, 1'b0);
    fl(8'h96);
    rd(`ADDR_RX_HOLD);
    cmp("rx_hold", 8'h3c, rv);
    // the armed empty-flag clear also drops tx_finished; the empty flag stays locked
    wr(`ADDR_FLAGS, 8'h00);
    fl(8'h82);
    serial_far_end_i.frame(8'h11, 1'b0, 1'b0, 1'b0);
    serial_far_end_i.frame(8'h22, 1'b0, 1'b0, 1'b0);
    fl(8'he0);
    rd(`ADDR_RX_HOLD);
    cmp("rx_hold", 8'h11, rv);
    cmp("rx_halt", 8'h01, rx_halt);
    cmp("tx_halt", 8'h00, tx_halt);
    wr(`ADDR_FORMAT, 8'h80);
    #1 cmp("tx_halt", 8'h01, tx_halt);
    wr(`ADDR_FORMAT, 8'h00);
    serial_far_end_i.frame(8'h44, 1'b1, 1'b0, 1'b1);
    fl(8'ha0);
    wr(`ADDR_CONTROL, 8'h00);
    fl(8'ha0);
    wr(`ADDR_FLAGS, 8'h00);
    fl(8'h80);
  endtask
  task automatic t_clk;
    for (n = 0; n < 8; n++) begin
      wr(`ADDR_CONTROL, {6'h00, n[1:0]});
      wr(`ADDR_FORMAT, {n[2], 7'h00});
      #1 cmp("sck_oe", {7'h00, !n[1] && (n[2] || n[0])}, sck_oe);
      cmp("ext_clk_sel", {7'h00, n[1]}, ext_clk_sel);
      cmp("sync_mode", {7'h00, n[2]}, sync_mode);
    end
    n = 0;
    // pulses sampled mid-cycle, away from the edge that launches them
    fork
      serial_far_end_i.clk_burst(3);
      repeat (60) @(negedge core_clk) n += clk_en;
    join
    cmp("ext_edges", 8'h03, n[7:0]);
    // async internal with output: one pin period per 16 ticks, a tick every 4 cycles
    wr(`ADDR_CONTROL, 8'h01);
    wr(`ADDR_FORMAT, 8'h00);
    n = 0;
    rv[0] = sck_out;
    repeat (256) begin
      @(negedge core_clk);
      n += (sck_out && !rv[0]);
      rv[0] = sck_out;
    end
    cmp("sck_rises", 8'h04, n[7:0]);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    rst_b = 1'b0;
    standby = 1'b0;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    tx_load = 1'b0;
    tx_last_bit = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    // scenarios race the hang limit; either way the report ends the run
    fork
      begin
        t_reset;
        t_tx;
        t_rx;
        t_clk;
      end
      begin
        wait (cyc == 5000);
        err_total++;
      end
    join_any
    final_report;
  end
endmodule
